// ### sbc_switch_ctrl.sv
// Control 3 registers, switch phase gating and comparator bus latch
// Notes on behaviour
// - Reference field picks ground, high, low, comparator
// - Comparator mode: node high gives high reference
// - Feedback capacitor switch bit zero keeps switch off
// - Bit set: on always, or phase two if zeroing
// - Ground switch bit gates switch with phase one
// - B switching: ground on one, input on two
// - B switching clear: continuous unswitched path
// - B select picks per instance neighbour output
// - Power field: zero off, else rising bias
// - Four control registers at listed indices
// - One driver per column comparator bus
// - Latched bus feeds digital and is readable
// - Bus latch transparent in phase two, holds
// - Switched blocks always latch, phase bit selects
// - Continuous blocks: two bits choose latching
// - Source select: zero bus, one phase two fall
//
// The APB slave port was left to the implementer.
module sbc_switch_ctrl (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [sbc_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic phase_one,
	input wire logic phase_two,
	input wire logic [3:0] zeroing_control,
	input wire logic [3:0] sc_output_phase,
	input wire logic [3:0] cmp_node,
	input wire logic [3:0] cmp_bus,
	input wire logic [3:0] ct_cmp_node,
	input wire logic [3:0] ct_latch_enable,
	input wire logic [3:0] ct_latch_phase,
	output logic [3:0] cmp_latched,
	output logic [3:0] sc_cmp_out,
	output logic [3:0] ct_cmp_out,
	output logic [3:0][1:0] reference_select,
	output logic [3:0] feedback_cap_switch,
	output logic [3:0] feedback_ground_switch,
	output logic [3:0] b_cap_ground,
	output logic [3:0] b_cap_input,
	output logic [3:0] b_continuous,
	output logic [3:0][3:0] b_input_select,
	output logic [3:0][1:0] power_level,
	output logic [3:0] block_on,
	output logic irq
);
	typedef struct packed {
		logic [3:0][7:0] cr3;
		logic [3:0] irq_sel;
		logic [3:0] irq_st;
		logic [3:0] irq_mask;
		logic [3:0] bus_lat;
		logic [3:0] bus_lat_d;
		logic ph2_d;
		logic [31:0] rdata;
		logic [3:0][1:0] ref_sel;
		logic [3:0] fb_cap;
		logic [3:0] fb_gnd;
		logic [3:0] b_gnd;
		logic [3:0] b_in;
		logic [3:0] b_ct;
		logic [3:0][3:0] b_src;
		logic [3:0][1:0] pwr;
		logic [3:0] on;
		logic irq;
	} sbc_state_t;

	sbc_state_t s_r;
	sbc_state_t s_nxt;

	logic ph1_s;
	logic ph2_s;
	logic [3:0] node_s;
	logic [3:0] bus_s;
	logic [3:0] ct_node_s;
	logic [7:0] idx_w;
	logic aligned_w;
	logic hit_w;
	logic wr_w;
	logic [3:0] ev_w;

	sbc_sync2 #(.W(2)) u_sync_ph (
		.pclk(pclk),
		.presetn(presetn),
		.d({phase_one, phase_two}),
		.q({ph1_s, ph2_s})
	);

	sbc_sync2 #(.W(12)) u_sync_cmp (
		.pclk(pclk),
		.presetn(presetn),
		.d({cmp_node, cmp_bus, ct_cmp_node}),
		.q({node_s, bus_s, ct_node_s})
	);

	genvar g;
	generate
		for (g = 0; g < sbc_pkg::NBLK; g++) begin : g_lat
			// Switched blocks latch unconditionally
			sbc_out_latch u_sc (
				.pclk(pclk),
				.presetn(presetn),
				.latch_en(1'b1),
				.phase_sel(sc_output_phase[g]),
				.ph1(ph1_s),
				.ph2(ph2_s),
				.d(node_s[g]),
				.q(sc_cmp_out[g])
			);
			// Continuous blocks choose whether and when
			sbc_out_latch u_ct (
				.pclk(pclk),
				.presetn(presetn),
				.latch_en(ct_latch_enable[g]),
				.phase_sel(ct_latch_phase[g]),
				.ph1(ph1_s),
				.ph2(ph2_s),
				.d(ct_node_s[g]),
				.q(ct_cmp_out[g])
			);
		end
	endgenerate

	// Register decode on word indices
	assign idx_w = paddr[9:2];
	assign aligned_w = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
	always_comb begin
		hit_w = 1'b0;
		if (aligned_w) begin
			case (idx_w)
				sbc_pkg::IDX_CMP,
				sbc_pkg::IDX_CR3_0,
				sbc_pkg::IDX_CR3_1,
				sbc_pkg::IDX_CR3_2,
				sbc_pkg::IDX_CR3_3,
				sbc_pkg::IDX_IRQ_ST,
				sbc_pkg::IDX_IRQ_MASK: hit_w = 1'b1;
				default: hit_w = 1'b0;
			endcase
		end
	end

	assign wr_w = psel && penable && pwrite && hit_w;

	// Interrupt events per column
	always_comb begin
		for (int c = 0; c < sbc_pkg::NCOL; c++) begin
			if (s_r.irq_sel[c]) begin
				ev_w[c] = s_r.ph2_d && !ph2_s;
			end else begin
				ev_w[c] = s_r.bus_lat[c] && !s_r.bus_lat_d[c];
			end
		end
	end

	always_comb begin
		logic [7:0] f;
		f = 8'h00;
		s_nxt = s_r;
		// Register writes take effect in the access phase
		if (wr_w && idx_w == sbc_pkg::IDX_CMP) begin
			// Latched bus bits are read only
			s_nxt.irq_sel = pwdata[sbc_pkg::CMP_SEL_LSB +: 4];
		end
		for (int b = 0; b < sbc_pkg::NBLK; b++) begin
			if (wr_w && idx_w == sbc_pkg::IDX_CR3[b]) begin
				s_nxt.cr3[b] = pwdata[7:0];
			end
		end
		if (wr_w && idx_w == sbc_pkg::IDX_IRQ_MASK) begin
			s_nxt.irq_mask = pwdata[3:0];
		end
		// Column bus follows while phase two high, else holds
		// Only one block drives each bus, so it is a plain level
		if (ph2_s) begin
			s_nxt.bus_lat = bus_s;
		end
		s_nxt.bus_lat_d = s_r.bus_lat;
		s_nxt.ph2_d = ph2_s;
		// Sticky status, a new event beats the clear
		if (wr_w && idx_w == sbc_pkg::IDX_IRQ_ST) begin
			s_nxt.irq_st = s_r.irq_st & ~pwdata[3:0];
		end
		s_nxt.irq_st = s_nxt.irq_st | ev_w;
		s_nxt.irq = |(s_nxt.irq_st & s_nxt.irq_mask);
		// Read data captured in the setup phase
		if (psel && !penable) begin
			s_nxt.rdata = 32'h0000_0000;
			if (aligned_w) begin
				case (idx_w)
					sbc_pkg::IDX_CMP: s_nxt.rdata[7:0] =
						{s_r.bus_lat, s_r.irq_sel};
					sbc_pkg::IDX_CR3_0: s_nxt.rdata[7:0] = s_r.cr3[0];
					sbc_pkg::IDX_CR3_1: s_nxt.rdata[7:0] = s_r.cr3[1];
					sbc_pkg::IDX_CR3_2: s_nxt.rdata[7:0] = s_r.cr3[2];
					sbc_pkg::IDX_CR3_3: s_nxt.rdata[7:0] = s_r.cr3[3];
					sbc_pkg::IDX_IRQ_ST: s_nxt.rdata[3:0] = s_r.irq_st;
					sbc_pkg::IDX_IRQ_MASK:
						s_nxt.rdata[3:0] = s_r.irq_mask;
					default: s_nxt.rdata = 32'h0000_0000;
				endcase
			end
		end
		// Switch and mux controls per block
		for (int b = 0; b < sbc_pkg::NBLK; b++) begin
			f = s_r.cr3[b];
			case (f[sbc_pkg::REF_MSB:sbc_pkg::REF_LSB])
				sbc_pkg::REF_AGND: s_nxt.ref_sel[b] = sbc_pkg::REF_AGND;
				sbc_pkg::REF_HIGH: s_nxt.ref_sel[b] = sbc_pkg::REF_HIGH;
				sbc_pkg::REF_LOW: s_nxt.ref_sel[b] = sbc_pkg::REF_LOW;
				default: s_nxt.ref_sel[b] = node_s[b] ?
					sbc_pkg::REF_HIGH : sbc_pkg::REF_LOW;
			endcase
			if (!f[sbc_pkg::FB_CAP_BIT]) begin
				s_nxt.fb_cap[b] = 1'b0;
			end else begin
				s_nxt.fb_cap[b] = !zeroing_control[b] || ph2_s;
			end
			s_nxt.fb_gnd[b] = f[sbc_pkg::FB_GND_BIT] && ph1_s;
			s_nxt.b_gnd[b] = f[sbc_pkg::B_SW_BIT] && ph1_s;
			s_nxt.b_in[b] = f[sbc_pkg::B_SW_BIT] && ph2_s;
			s_nxt.b_ct[b] = !f[sbc_pkg::B_SW_BIT];
			s_nxt.b_src[b] =
				sbc_pkg::B_SRC[b][f[sbc_pkg::B_SEL_BIT]];
			s_nxt.pwr[b] = f[sbc_pkg::PWR_MSB:sbc_pkg::PWR_LSB];
			s_nxt.on[b] = (f[sbc_pkg::PWR_MSB:sbc_pkg::PWR_LSB]
				!= sbc_pkg::PWR_OFF);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
			s_r.cr3 <= {4{sbc_pkg::CR3_RESET}};
			s_r.irq_sel <= sbc_pkg::CMP_SEL_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit_w;
	assign prdata = s_r.rdata;
	assign cmp_latched = s_r.bus_lat;
	assign reference_select = s_r.ref_sel;
	assign feedback_cap_switch = s_r.fb_cap;
	assign feedback_ground_switch = s_r.fb_gnd;
	assign b_cap_ground = s_r.b_gnd;
	assign b_cap_input = s_r.b_in;
	assign b_continuous = s_r.b_ct;
	assign b_input_select = s_r.b_src;
	assign power_level = s_r.pwr;
	assign block_on = s_r.on;
	assign irq = s_r.irq;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	generate
		for (g = 0; g < sbc_pkg::NBLK; g++) begin : g_chk
			fb_cap_off_a: assert property (
				!s_r.cr3[g][sbc_pkg::FB_CAP_BIT]
				|=> !feedback_cap_switch[g])
				else $error("feedback switch on with bit clear");
			fb_cap_zero_a: assert property (
				s_r.cr3[g][sbc_pkg::FB_CAP_BIT] && zeroing_control[g]
				|=> feedback_cap_switch[g] == $past(ph2_s))
				else $error("feedback switch not on phase two");
			fb_cap_cont_a: assert property (
				s_r.cr3[g][sbc_pkg::FB_CAP_BIT] && !zeroing_control[g]
				|=> feedback_cap_switch[g])
				else $error("feedback switch not continuous");
			fb_gnd_gate_a: assert property (
				feedback_ground_switch[g] |->
				$past(ph1_s) && $past(s_r.cr3[g][sbc_pkg::FB_GND_BIT]))
				else $error("ground switch outside phase one");
			ref_cmp_a: assert property (
				s_r.cr3[g][sbc_pkg::REF_MSB:sbc_pkg::REF_LSB]
				== sbc_pkg::REF_CMP
				|=> reference_select[g] == ($past(node_s[g]) ?
				sbc_pkg::REF_HIGH : sbc_pkg::REF_LOW))
				else $error("comparator reference wrong");
			b_phase_a: assert property (
				!(b_cap_ground[g] && b_cap_input[g]))
				else $error("B branch ground and input together");
			power_off_a: assert property (
				s_r.cr3[g][sbc_pkg::PWR_MSB:sbc_pkg::PWR_LSB]
				== sbc_pkg::PWR_OFF |=> !block_on[g])
				else $error("block on with power off");
			ref_fixed_a: assert property (
				s_r.cr3[g][sbc_pkg::REF_MSB:sbc_pkg::REF_LSB]
				!= sbc_pkg::REF_CMP |=> reference_select[g] ==
				$past(s_r.cr3[g][sbc_pkg::REF_MSB:sbc_pkg::REF_LSB]))
				else $error("fixed reference wrong");
			b_cont_a: assert property (
				!s_r.cr3[g][sbc_pkg::B_SW_BIT] |=> b_continuous[g]
				&& !b_cap_ground[g] && !b_cap_input[g])
				else $error("B branch not continuous");
			b_input_a: assert property (
				s_r.cr3[g][sbc_pkg::B_SW_BIT] && ph2_s
				|=> b_cap_input[g] && !b_continuous[g])
				else $error("B input not switched on phase two");
			b_ground_a: assert property (
				s_r.cr3[g][sbc_pkg::B_SW_BIT] && ph1_s |=> b_cap_ground[g])
				else $error("B ground not switched on phase one");
			b_sel_one_a: assert property (
				s_r.cr3[g][sbc_pkg::B_SEL_BIT]
				|=> b_input_select[g] == sbc_pkg::B_SRC[g][1])
				else $error("B input neighbour wrong for one");
			b_sel_zero_a: assert property (
				!s_r.cr3[g][sbc_pkg::B_SEL_BIT]
				|=> b_input_select[g] == sbc_pkg::B_SRC[g][0])
				else $error("B input neighbour wrong for zero");
			power_copy_a: assert property (
				1'b1 |=> power_level[g] ==
				$past(s_r.cr3[g][sbc_pkg::PWR_MSB:sbc_pkg::PWR_LSB]))
				else $error("power level not copied");
			sc_hold_a: assert property (
				(sc_output_phase[g] ? !ph1_s : !ph2_s)
				|=> $stable(sc_cmp_out[g]))
				else $error("block latch open on wrong phase");
		end
	endgenerate

	lat_track_a: assert property (
		ph2_s |=> cmp_latched == $past(bus_s))
		else $error("bus latch not transparent");
	lat_hold_a: assert property (
		!ph2_s |=> $stable(cmp_latched))
		else $error("bus latch changed while phase two low");
	irq_fall_a: assert property (
		s_r.irq_sel[0] && s_r.ph2_d && !ph2_s |=> s_r.irq_st[0])
		else $error("phase two fall missed");
	irq_rise_a: assert property (
		!s_r.irq_sel[1] && $rose(s_r.bus_lat[1]) ##1 1'b1
		|-> s_r.irq_st[1])
		else $error("bus rise missed");
	irq_level_a: assert property (
		##1 irq == |(s_r.irq_st & s_r.irq_mask))
		else $error("interrupt level wrong");
	cr3_write_a: assert property (
		wr_w && idx_w == sbc_pkg::IDX_CR3_2
		|=> s_r.cr3[2] == $past(pwdata[7:0]))
		else $error("control write lost");
	st_sticky_a: assert property (
		s_r.irq_st[0] && !(wr_w && pwdata[0]
		&& idx_w == sbc_pkg::IDX_IRQ_ST) |=> s_r.irq_st[0])
		else $error("status bit lost without clear");
	set_wins_a: assert property (
		ev_w[0] |=> s_r.irq_st[0])
		else $error("event lost to clear");
endmodule

// ### sbc_pkg.sv
// Constants shared by the switch control and comparator bus block
package sbc_pkg;
	localparam int ADDR_W = 12;
	localparam int NBLK = 4;
	localparam int NCOL = 4;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_CMP = 8'h64;
	localparam logic [7:0] IDX_CR3_0 = 8'h87;
	localparam logic [7:0] IDX_CR3_1 = 8'h8F;
	localparam logic [7:0] IDX_CR3_2 = 8'h93;
	localparam logic [7:0] IDX_CR3_3 = 8'h9B;
	localparam logic [7:0] IDX_IRQ_ST = 8'hA0;
	localparam logic [7:0] IDX_IRQ_MASK = 8'hA1;
	localparam logic [3:0][7:0] IDX_CR3 =
		{IDX_CR3_3, IDX_CR3_2, IDX_CR3_1, IDX_CR3_0};
	// Control 3 field positions
	localparam int REF_MSB = 7;
	localparam int REF_LSB = 6;
	localparam int FB_CAP_BIT = 5;
	localparam int FB_GND_BIT = 4;
	localparam int B_SW_BIT = 3;
	localparam int B_SEL_BIT = 2;
	localparam int PWR_MSB = 1;
	localparam int PWR_LSB = 0;
	// Comparator status register fields
	localparam int CMP_LAT_LSB = 4;
	localparam int CMP_SEL_LSB = 0;
	localparam logic [7:0] CR3_RESET = 8'h00;
	localparam logic [3:0] CMP_SEL_RESET = 4'h0;
	// Reference select codes
	localparam logic [1:0] REF_AGND = 2'h0;
	localparam logic [1:0] REF_HIGH = 2'h1;
	localparam logic [1:0] REF_LOW = 2'h2;
	localparam logic [1:0] REF_CMP = 2'h3;
	localparam logic [1:0] PWR_OFF = 2'h0;
	// Neighbour block identifiers for the B input
	localparam logic [3:0] SRC_CT_COL0 = 4'h0;
	localparam logic [3:0] SRC_CT_COL1 = 4'h1;
	localparam logic [3:0] SRC_CT_COL2 = 4'h2;
	localparam logic [3:0] SRC_CT_COL3 = 4'h3;
	localparam logic [3:0] SRC_SCA_COL1 = 4'h4;
	localparam logic [3:0] SRC_SCA_COL3 = 4'h5;
	localparam logic [3:0] SRC_SCB_COL0 = 4'h6;
	localparam logic [3:0] SRC_SCB_COL2 = 4'h7;
	// Per instance: [block][select bit]
	localparam logic [3:0][1:0][3:0] B_SRC = {
		{SRC_SCB_COL2, SRC_SCA_COL3},
		{SRC_SCB_COL0, SRC_SCA_COL1},
		{SRC_CT_COL3, SRC_CT_COL2},
		{SRC_CT_COL1, SRC_CT_COL0}};
endpackage

// ### sbc_sync2.sv
// Two flip-flop synchroniser for a vector of levels
module sbc_sync2 #(
	parameter int W = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} sbc_sync_t;

	sbc_sync_t s_r;
	sbc_sync_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.meta = d;
		s_nxt.sync = s_r.meta;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign q = s_r.sync;
endmodule

// ### sbc_out_latch.sv
// Comparator output latch of one analog block
module sbc_out_latch (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic latch_en,
	input wire logic phase_sel,
	input wire logic ph1,
	input wire logic ph2,
	input wire logic d,
	output logic q
);
	typedef struct packed {
		logic q;
	} sbc_lat_t;

	sbc_lat_t s_r;
	sbc_lat_t s_nxt;
	logic open_w;

	// Selected phase 0 tracks during phase two, 1 during phase one
	assign open_w = !latch_en || (phase_sel ? ph1 : ph2);

	always_comb begin
		s_nxt = s_r;
		if (open_w) begin
			s_nxt.q = d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign q = s_r.q;
endmodule

// ### tb_sc_switch_ctrl_and_comparator_bus.sv
// Self-checking bench for the switch control and comparator bus block
module tb_sc_switch_ctrl_and_comparator_bus;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
	logic pwrite = 1'h0, phase_one = 1'h0, phase_two = 1'h0;
	logic [sbc_pkg::ADDR_W-1:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, irq;
	logic [3:0] zeroing_control = 4'h0, sc_output_phase = 4'h0;
	logic [3:0] cmp_node = 4'h0, cmp_bus = 4'h0, ct_cmp_node = 4'h0;
	logic [3:0] ct_latch_enable = 4'h0, ct_latch_phase = 4'h0;
	logic [3:0] cmp_latched, sc_cmp_out, ct_cmp_out, feedback_cap_switch;
	logic [3:0] feedback_ground_switch, b_cap_ground, b_cap_input;
	logic [3:0] b_continuous, block_on;
	logic [3:0][1:0] reference_select, power_level;
	logic [3:0][3:0] b_input_select;
	int errors = 0;
	int num_checks = 0;

	sbc_switch_ctrl sbc_switch_ctrl_i (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .phase_one, .phase_two, .zeroing_control,
		.sc_output_phase, .cmp_node, .cmp_bus, .ct_cmp_node, .ct_latch_enable,
		.ct_latch_phase, .cmp_latched, .sc_cmp_out, .ct_cmp_out,
		.reference_select, .feedback_cap_switch, .feedback_ground_switch,
		.b_cap_ground, .b_cap_input, .b_continuous, .b_input_select,
		.power_level, .block_on, .irq
	);

	always #4 pclk = ~pclk;

	task automatic final_report();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, g);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] idx,
		input logic [31:0] wd, output logic [31:0] rd, output logic err);
		int n;
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'h1;
		for (n = 0; n < 16; n++) begin
			@(posedge pclk);
			if (pready === 1'h1)
				break;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (n == 16) begin
			errors++;
			$display("[FAIL] pready expected 1 seen timeout");
			final_report();
		end
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] rd;
		logic err;
		apb(1'h1, idx, {24'h0, d}, rd, err);
	endtask

	task automatic rdchk(input string n, input logic [7:0] idx,
		input logic [31:0] e);
		logic [31:0] rd;
		logic err;
		apb(1'h0, idx, 32'h0, rd, err);
		chk(n, e, rd);
	endtask

	task automatic wr_all(input logic [7:0] d);
		for (int b = 0; b < 4; b++)
			wr(sbc_pkg::IDX_CR3[b], d);
	endtask

	// Pins pass two sync flops and one output flop
	task automatic settle();
		repeat (4) @(posedge pclk);
		#1;
	endtask

	task automatic drive(input logic p1, p2);
		@(posedge pclk) begin
			phase_one <= p1;
			phase_two <= p2;
		end
		settle();
	endtask

	task automatic t_reset();
		for (int b = 0; b < 4; b++)
			rdchk("cr3 rst", sbc_pkg::IDX_CR3[b], 32'h0);
		rdchk("cmp rst", sbc_pkg::IDX_CMP, 32'h0);
		rdchk("irq st rst", sbc_pkg::IDX_IRQ_ST, 32'h0);
		rdchk("irq mask rst", sbc_pkg::IDX_IRQ_MASK, 32'h0);
		chk("block_on rst", 32'h0, {28'h0, block_on});
	endtask

	task automatic t_regs();
		logic [31:0] rd;
		logic err;
		for (int b = 0; b < 4; b++)
			wr(sbc_pkg::IDX_CR3[b], 8'hA5 + 8'(b));
		for (int b = 0; b < 4; b++)
			rdchk("cr3 rb", sbc_pkg::IDX_CR3[b], 32'hA5 + b);
		wr(sbc_pkg::IDX_CMP, 8'hFF);
		rdchk("cmp ro", sbc_pkg::IDX_CMP, 32'h0F);
		wr(sbc_pkg::IDX_CMP, 8'h00);
		apb(1'h1, 8'h10, 32'hFF, rd, err);
		chk("unmapped err", 32'h1, {31'h0, err});
		apb(1'h0, 8'h10, 32'h0, rd, err);
		chk("unmapped rd", 32'h0, rd);
	endtask

	task automatic chk_ref(input int c);
		logic [1:0] e;
		for (int b = 0; b < 4; b++) begin
			e = cmp_node[b] ? sbc_pkg::REF_HIGH : sbc_pkg::REF_LOW;
			if (c != 3)
				e = 2'(c);
			chk("reference_select", 32'(e), 32'(reference_select[b]));
		end
	endtask

	task automatic t_ref();
		@(posedge pclk) cmp_node <= 4'h5;
		for (int c = 0; c < 4; c++) begin
			wr_all(8'(c << 6));
			settle();
			chk_ref(c);
		end
		@(posedge pclk) cmp_node <= 4'hA;
		settle();
		chk_ref(3);
	endtask

	task automatic t_fb();
		@(posedge pclk) zeroing_control <= 4'hF;
		wr_all(8'h00);
		drive(1'h0, 1'h1);
		chk("fcap off", 32'h0, 32'(feedback_cap_switch));
		chk("fgnd off", 32'h0, 32'(feedback_ground_switch));
		wr_all(8'h30);
		zeroing_control <= 4'h0;
		drive(1'h1, 1'h0);
		chk("fcap cont", 32'hF, 32'(feedback_cap_switch));
		chk("fgnd ph1", 32'hF, 32'(feedback_ground_switch));
		@(posedge pclk) zeroing_control <= 4'hF;
		settle();
		chk("fcap zero", 32'h0, 32'(feedback_cap_switch));
		drive(1'h0, 1'h1);
		chk("fcap ph2", 32'hF, 32'(feedback_cap_switch));
		chk("fgnd ph2", 32'h0, 32'(feedback_ground_switch));
	endtask

	task automatic t_bbr();
		wr_all(8'h08);
		drive(1'h1, 1'h0);
		chk("bgnd ph1", 32'hF, 32'(b_cap_ground));
		chk("bin ph1", 32'h0, 32'(b_cap_input));
		chk("bcont sw", 32'h0, 32'(b_continuous));
		drive(1'h0, 1'h1);
		chk("bgnd ph2", 32'h0, 32'(b_cap_ground));
		chk("bin ph2", 32'hF, 32'(b_cap_input));
		wr_all(8'h00);
		settle();
		chk("bcont", 32'hF, 32'(b_continuous));
		chk("bin ct", 32'h0, 32'(b_cap_input));
	endtask

	task automatic t_sel_pwr();
		logic [2:0] v;
		logic [3:0] src;
		for (int c = 0; c < 8; c++) begin
			v = 3'(c);
			wr_all({5'h0, v});
			settle();
			for (int b = 0; b < 4; b++) begin
				src = sbc_pkg::B_SRC[b][v[2]];
				chk("bsel", 32'(src), 32'(b_input_select[b]));
				chk("pwr", 32'(v[1:0]), 32'(power_level[b]));
				chk("on", 32'(v[1:0] != 2'h0), 32'(block_on[b]));
			end
		end
	endtask

	task automatic t_latch();
		drive(1'h0, 1'h1);
		@(posedge pclk) cmp_bus <= 4'h9;
		settle();
		chk("bus transp", 32'h9, 32'(cmp_latched));
		rdchk("cmp rd", sbc_pkg::IDX_CMP, 32'h90);
		drive(1'h0, 1'h0);
		@(posedge pclk) cmp_bus <= 4'h6;
		settle();
		chk("bus hold", 32'h9, 32'(cmp_latched));
		drive(1'h0, 1'h1);
		chk("bus open", 32'h6, 32'(cmp_latched));
		@(posedge pclk) cmp_bus <= 4'h0;
		settle();
	endtask

	task automatic t_blk();
		@(posedge pclk) cmp_node <= 4'hF;
		settle();
		chk("sc ph2", 32'hF, 32'(sc_cmp_out));
		drive(1'h0, 1'h0);
		@(posedge pclk) cmp_node <= 4'h0;
		settle();
		chk("sc hold", 32'hF, 32'(sc_cmp_out));
		@(posedge pclk) sc_output_phase <= 4'hF;
		drive(1'h1, 1'h0);
		chk("sc ph1", 32'h0, 32'(sc_cmp_out));
		@(posedge pclk) ct_cmp_node <= 4'h3;
		settle();
		chk("ct transp", 32'h3, 32'(ct_cmp_out));
		@(posedge pclk) ct_latch_enable <= 4'hF;
		drive(1'h0, 1'h1);
		drive(1'h0, 1'h0);
		@(posedge pclk) ct_cmp_node <= 4'hC;
		settle();
		chk("ct hold", 32'h3, 32'(ct_cmp_out));
		drive(1'h0, 1'h1);
		chk("ct ph2", 32'hC, 32'(ct_cmp_out));
		@(posedge pclk) begin
			ct_latch_phase <= 4'hF;
			ct_cmp_node <= 4'h5;
		end
		settle();
		chk("ct ph1 hold", 32'hC, 32'(ct_cmp_out));
		drive(1'h1, 1'h0);
		chk("ct ph1", 32'h5, 32'(ct_cmp_out));
		drive(1'h0, 1'h1);
	endtask

	task automatic t_irq();
		wr(sbc_pkg::IDX_IRQ_ST, 8'h0F);
		wr(sbc_pkg::IDX_CMP, 8'h01);
		drive(1'h0, 1'h0);
		rdchk("st fall", sbc_pkg::IDX_IRQ_ST, 32'h1);
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(sbc_pkg::IDX_IRQ_MASK, 8'h01);
		settle();
		chk("irq on", 32'h1, {31'h0, irq});
		wr(sbc_pkg::IDX_IRQ_ST, 8'h01);
		settle();
		chk("irq clr", 32'h0, {31'h0, irq});
		wr(sbc_pkg::IDX_CMP, 8'h00);
		drive(1'h0, 1'h1);
		@(posedge pclk) cmp_bus <= 4'h2;
		settle();
		rdchk("st bus", sbc_pkg::IDX_IRQ_ST, 32'h2);
		chk("irq mask1", 32'h0, {31'h0, irq});
	endtask

	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'h1;
		t_reset();
		t_regs();
		t_ref();
		t_fb();
		t_bbr();
		t_sel_pwr();
		t_latch();
		t_blk();
		t_irq();
		final_report();
	end
endmodule
